// file: common/sba_pkg.sv
// Shared constants, types and encodings of the system bus arbiter
package sba_pkg;

  // Bus clock period and the analogue settle times the commands must respect
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned CMD_SETTLE_NS  = 100;
  localparam int unsigned ADDR_SETUP_NS  = 50;

  // Least times round up to whole clock cycles
  localparam int unsigned CMD_SETTLE_CYC = (CMD_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CMD_DELAY_CYC  = (CMD_SETTLE_CYC > ADDR_SETUP_CYC) ?
                                           CMD_SETTLE_CYC : ADDR_SETUP_CYC;
  localparam int unsigned SETTLE_W       = 5;

  // Slave acknowledge latency of the far-end model, in clock cycles
  localparam int unsigned XACK_DELAY_CYC = 4;
  localparam int unsigned XACK_W         = 4;

  // Number of competing masters seen by the far end, and our rank among them
  localparam int unsigned NUM_OTHERS     = 3;
  localparam int unsigned OUR_RANK       = 1;

  // Bit positions of the master-side levels carried through the synchronizer
  localparam int unsigned SYNC_REQ       = 0;
  localparam int unsigned SYNC_RD        = 1;
  localparam int unsigned SYNC_WR        = 2;
  localparam int unsigned SYNC_MEM       = 3;
  localparam int unsigned SYNC_W         = 4;

  // Bus lines are active low; an undriven line floats to the idle level
  localparam logic BUS_ASSERTED = 1'b0;
  localparam logic BUS_IDLE     = 1'b1;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_WAIT = 2'b01,
    ARB_OWN  = 2'b10,
    ARB_PARK = 2'b11
  } sba_arb_state_e;

  typedef enum logic [1:0] {
    SLV_IDLE  = 2'b00,
    SLV_COUNT = 2'b01,
    SLV_ACK   = 2'b10
  } sba_slv_state_e;

endpackage : sba_pkg

// file: common/sba_bus_if.sv
// System bus wires between one arbiter and the rest of the bus
`timescale 1ns/1ps
`default_nettype none
interface sba_bus_if;
  logic bprn_n;
  logic bpro_n;
  logic breq_n;
  logic busy_arb_o;
  logic busy_arb_oe;
  logic busy_far_o;
  logic busy_far_oe;
  logic cbreq_arb_o;
  logic cbreq_arb_oe;
  logic cbreq_far_o;
  logic cbreq_far_oe;
  logic busy_n;
  logic cbreq_n;
  logic adr_en_n;
  logic mrdc_n;
  logic mwtc_n;
  logic iorc_n;
  logic iowc_n;
  logic xack_n;

  // Open-collector lines: low while any enabled driver pulls low
  assign busy_n  = ~((busy_arb_oe & ~busy_arb_o) | (busy_far_oe & ~busy_far_o));
  assign cbreq_n = ~((cbreq_arb_oe & ~cbreq_arb_o) | (cbreq_far_oe & ~cbreq_far_o));

  modport device (
    input  bprn_n, busy_n, cbreq_n, xack_n,
    output bpro_n, breq_n, busy_arb_o, busy_arb_oe, cbreq_arb_o, cbreq_arb_oe,
    output adr_en_n, mrdc_n, mwtc_n, iorc_n, iowc_n
  );

  modport far (
    input  bpro_n, breq_n, busy_n, cbreq_n, adr_en_n, mrdc_n, mwtc_n, iorc_n, iowc_n,
    output bprn_n, busy_far_o, busy_far_oe, cbreq_far_o, cbreq_far_oe, xack_n
  );
endinterface : sba_bus_if
`default_nettype wire

// file: src/sba_sync.sv
// Two-stage synchronizer for master-side levels
`timescale 1ns/1ps
`default_nettype none
module sba_sync
  import sba_pkg::*;
#(
  parameter int unsigned WIDTH = SYNC_W
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] level_in,
  output var  logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sba_sync_s;

  sba_sync_s r;
  sba_sync_s next_r;

  // Stage one is read by stage two only, never by logic
  always_comb begin
    next_r        = r;
    next_r.stage1 = level_in;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_out = r.stage2;

endmodule // sba_sync
`default_nettype wire

// file: src/sba_arbiter.sv
// Per-master system bus arbiter: request sync, grant logic, command sequencing
//
// Summary of operation
// R1: Request needs transfer request plus read/write.
// R2: Qualified request crosses two synchronizer stages.
// R3: External request registered before grant logic.
// R4: Serial mode: drop priority-out once synchronized.
// R5: Parallel mode: assert BREQ and CBREQ.
// R6: Priority and bus free: grant, assert BUSY.
// R7: Address enable leads command enable.
// R8: Bus status picks acquire, release or hold.
// R9: Overruled owner finishes current transfer only.
// R10: Overruled master waits for priority again.
// R11: Command enable is delayed grant, 100 ns.
// R12: Address valid 50 ns before commands.
// R13: Owner asserts command and address enable.
// R14: Slave returns XACK per completed transfer.
// R15: Reset clears all registers synchronously.
// R16: BUSY, CBREQ driven only while asserted.
// R17: Keep bus while requesting, no higher request.
// R18: Park on bus when nobody else requests.
// R19: Arbitration sampled and changed on bus clock.
// R20: Bus control lines are active low.
// R21: Serial chain: priority-out feeds next priority-in.
// R22: Parallel decoder grants highest requester only.
// R23: Reset holds all bus outputs inactive.
// R24: Command enable drops after request withdrawn.
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter
  import sba_pkg::*;
#(
  parameter int unsigned CMD_DELAY = CMD_DELAY_CYC
) (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  input  wire logic           master_transfer_request_in,
  input  wire logic           read_req_in,
  input  wire logic           write_req_in,
  input  wire logic           mem_space_in,
  sba_bus_if.device           bus,
  output var  logic           address_enable_grant_out,
  output var  logic           command_output_enable_out,
  output var  logic [1:0]     arb_state_out
);

  // Cycles between grant and command enable, at least one
  localparam int unsigned     DELAY_USED = (CMD_DELAY < 1) ? 1 : CMD_DELAY;
  localparam logic [SETTLE_W-1:0] DELAY_LAST = SETTLE_W'(DELAY_USED - 1);

  typedef struct packed {
    sba_arb_state_e        state;
    logic                  address_enable_grant;
    logic                  command_output_enable;
    logic [SETTLE_W-1:0]   settle;
    logic                  bpro_n;
    logic                  breq_n;
    logic                  busy_oe;
    logic                  cbreq_oe;
    logic                  adr_en_n;
    logic                  mrdc_n;
    logic                  mwtc_n;
    logic                  iorc_n;
    logic                  iowc_n;
  } sba_arb_s;

  // R23: reset image, all bus lines idle
  localparam sba_arb_s ARB_RESET = '{
    state:    ARB_IDLE,
    address_enable_grant:      1'b0,
    command_output_enable:      1'b0,
    settle:   '0,
    bpro_n:   BUS_IDLE,
    breq_n:   BUS_IDLE,
    busy_oe:  1'b0,
    cbreq_oe: 1'b0,
    adr_en_n: BUS_IDLE,
    mrdc_n:   BUS_IDLE,
    mwtc_n:   BUS_IDLE,
    iorc_n:   BUS_IDLE,
    iowc_n:   BUS_IDLE
  };

  sba_arb_s         r;
  sba_arb_s         next_r;
  logic [SYNC_W-1:0] raw_level;
  logic [SYNC_W-1:0] sync_level;
  logic             req;
  logic             rd_s;
  logic             wr_s;
  logic             mem_s;
  logic             prio;
  logic             busy_seen;
  logic             cbreq_seen;
  logic             xack_seen;
  logic             granted;
  logic             settled;

  // R1: qualified request before synchronization
  always_comb begin
    raw_level           = '0;
    raw_level[SYNC_REQ] = master_transfer_request_in & (read_req_in | write_req_in);
    raw_level[SYNC_RD]  = read_req_in;
    raw_level[SYNC_WR]  = write_req_in;
    raw_level[SYNC_MEM] = mem_space_in;
  end

  // R2: two flip-flop synchronizer on master levels
  sba_sync #(
    .WIDTH      (SYNC_W)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .level_in   (raw_level),
    .level_out  (sync_level)
  );

  // R3: grant logic sees only the registered request
  assign req   = sync_level[SYNC_REQ];
  assign rd_s  = sync_level[SYNC_RD];
  assign wr_s  = sync_level[SYNC_WR];
  assign mem_s = sync_level[SYNC_MEM];

  // R20: bus lines read as active low
  assign prio       = (bus.bprn_n == BUS_ASSERTED);
  assign busy_seen  = (bus.busy_n == BUS_ASSERTED);
  assign cbreq_seen = (bus.cbreq_n == BUS_ASSERTED);
  assign xack_seen  = (bus.xack_n == BUS_ASSERTED);

  always_comb begin
    next_r  = r;
    granted = 1'b0;
    settled = 1'b0;

    // R8: grant state chosen from bus status
    case (r.state)
      ARB_IDLE: begin
        if (req) begin
          next_r.state = ARB_WAIT;
        end
      end
      ARB_WAIT: begin
        // R10: only retake bus with priority
        if (!req) begin
          next_r.state = ARB_IDLE;
        // R6: grant when priority held and bus free
        end else if (prio && !busy_seen) begin
          next_r.state = ARB_OWN;
        end
      end
      ARB_OWN: begin
        if (!prio) begin
          // R9: overruled owner ends at transfer acknowledge
          if (!req) begin
            next_r.state = ARB_IDLE;
          end else if (xack_seen) begin
            next_r.state = ARB_WAIT;
          end
        end else if (!req) begin
          // R18: park unless another master asks
          next_r.state = cbreq_seen ? ARB_IDLE : ARB_PARK;
        end
        // R17: otherwise the bus is kept
      end
      ARB_PARK: begin
        if (!prio) begin
          next_r.state = req ? ARB_WAIT : ARB_IDLE;
        end else if (req) begin
          // R17: parked owner resumes without arbitration
          next_r.state = ARB_OWN;
        end else if (cbreq_seen) begin
          next_r.state = ARB_IDLE;
        end
      end
      default: begin
        next_r.state = ARB_IDLE;
      end
    endcase

    granted    = (next_r.state == ARB_OWN) || (next_r.state == ARB_PARK);
    next_r.address_enable_grant = granted;

    // R4: block lower-priority masters while requesting
    next_r.bpro_n = (prio && !req) ? BUS_ASSERTED : BUS_IDLE;

    // R5: announce the request to the other arbiters
    next_r.breq_n   = req ? BUS_ASSERTED : BUS_IDLE;
    // R16: common request pulled low only while pending
    next_r.cbreq_oe = req && !granted;
    // R16: busy pulled low only while the bus is ours
    next_r.busy_oe  = granted;

    // R7: address enable goes active at the grant
    next_r.adr_en_n = granted ? BUS_ASSERTED : BUS_IDLE;

    // R12: count cycles of stable address before commands
    if (r.address_enable_grant && granted) begin
      if (r.settle != DELAY_LAST) begin
        next_r.settle = r.settle + SETTLE_W'(1);
      end
    end else begin
      next_r.settle = '0;
    end
    settled = (r.settle == DELAY_LAST);

    // R11: command enable is the grant delayed DELAY_USED cycles by the settle count
    // R24: withdrawn request drops command enable next clock
    next_r.command_output_enable = r.address_enable_grant && granted && req && settled;

    // R13: command strobe chosen by direction and space
    next_r.mrdc_n = (next_r.command_output_enable && rd_s && mem_s)  ? BUS_ASSERTED : BUS_IDLE;
    next_r.mwtc_n = (next_r.command_output_enable && wr_s && mem_s)  ? BUS_ASSERTED : BUS_IDLE;
    next_r.iorc_n = (next_r.command_output_enable && rd_s && !mem_s) ? BUS_ASSERTED : BUS_IDLE;
    next_r.iowc_n = (next_r.command_output_enable && wr_s && !mem_s) ? BUS_ASSERTED : BUS_IDLE;
  end

  // R15: synchronous reset of every register
  // R19: all arbitration lines change on the bus clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= ARB_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Open-collector drivers only ever pull low
  assign bus.bpro_n       = r.bpro_n;
  assign bus.breq_n       = r.breq_n;
  assign bus.busy_arb_o   = BUS_ASSERTED;
  assign bus.busy_arb_oe  = r.busy_oe;
  assign bus.cbreq_arb_o  = BUS_ASSERTED;
  assign bus.cbreq_arb_oe = r.cbreq_oe;
  assign bus.adr_en_n     = r.adr_en_n;
  assign bus.mrdc_n       = r.mrdc_n;
  assign bus.mwtc_n       = r.mwtc_n;
  assign bus.iorc_n       = r.iorc_n;
  assign bus.iowc_n       = r.iowc_n;

  assign address_enable_grant_out  = r.address_enable_grant;
  assign command_output_enable_out = r.command_output_enable;
  assign arb_state_out             = r.state;

endmodule // sba_arbiter
`default_nettype wire

// file: src/sba_bus_end.sv
// Far end of the bus: priority resolution, other masters' lines, slave acknowledge
`timescale 1ns/1ps
`default_nettype none
module sba_bus_end
  import sba_pkg::*;
#(
  parameter int unsigned N_OTHERS   = NUM_OTHERS,
  parameter int unsigned RANK       = OUR_RANK,
  parameter int unsigned XACK_DELAY = XACK_DELAY_CYC
) (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_in,
  input  wire logic                serial_mode_in,
  input  wire logic                chain_prio_in,
  input  wire logic [N_OTHERS-1:0] other_breq_in,
  input  wire logic                other_busy_in,
  input  wire logic                other_cbreq_in,
  sba_bus_if.far                   bus,
  output var  logic [N_OTHERS-1:0] other_grant_out,
  output var  logic                chain_prio_out
);

  localparam logic [XACK_W-1:0] XACK_LAST = XACK_W'((XACK_DELAY < 1) ? 0 : XACK_DELAY - 1);

  typedef struct packed {
    sba_slv_state_e       slv;
    logic [XACK_W-1:0]    cnt;
    logic                 xack_n;
    logic                 bprn_n;
    logic [N_OTHERS-1:0]  grant;
    logic                 chain;
    logic                 busy_oe;
    logic                 cbreq_oe;
  } sba_far_s;

  sba_far_s            r;
  sba_far_s            next_r;
  logic [N_OTHERS:0]   higher;
  logic [N_OTHERS-1:0] win;
  logic                ours_req;
  logic                cmd_on;

  assign ours_req = (bus.breq_n == BUS_ASSERTED);
  assign cmd_on   = (bus.mrdc_n == BUS_ASSERTED) || (bus.mwtc_n == BUS_ASSERTED) ||
                    (bus.iorc_n == BUS_ASSERTED) || (bus.iowc_n == BUS_ASSERTED);

  // Index 0 is the highest-priority other master; ours sits at RANK
  assign higher[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < N_OTHERS; gi++) begin : g_prio
      assign higher[gi+1] = higher[gi] | other_breq_in[gi];
      assign win[gi]      = other_breq_in[gi] && !higher[gi] && !(ours_req && (RANK <= gi));
    end
  endgenerate

  always_comb begin
    next_r = r;
    // R22: parallel decoder, R21: serial chain input
    if (serial_mode_in) begin
      next_r.bprn_n = chain_prio_in ? BUS_ASSERTED : BUS_IDLE;
    end else begin
      next_r.bprn_n = higher[(RANK < N_OTHERS) ? RANK : N_OTHERS] ? BUS_IDLE : BUS_ASSERTED;
    end
    next_r.grant    = win;
    next_r.chain    = (bus.bpro_n == BUS_ASSERTED);
    next_r.busy_oe  = other_busy_in;
    next_r.cbreq_oe = other_cbreq_in;

    // R14: acknowledge each command after a fixed latency
    case (r.slv)
      SLV_IDLE: begin
        next_r.cnt = '0;
        if (cmd_on) begin
          next_r.slv = SLV_COUNT;
        end
      end
      SLV_COUNT: begin
        if (!cmd_on) begin
          next_r.slv = SLV_IDLE;
        end else if (r.cnt == XACK_LAST) begin
          next_r.slv    = SLV_ACK;
          next_r.xack_n = BUS_ASSERTED;
        end else begin
          next_r.cnt = r.cnt + XACK_W'(1);
        end
      end
      SLV_ACK: begin
        if (!cmd_on) begin
          next_r.slv    = SLV_IDLE;
          next_r.xack_n = BUS_IDLE;
        end
      end
      default: begin
        next_r.slv    = SLV_IDLE;
        next_r.xack_n = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= '{slv: SLV_IDLE, cnt: '0, xack_n: BUS_IDLE, bprn_n: BUS_IDLE,
             grant: '0, chain: 1'b0, busy_oe: 1'b0, cbreq_oe: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign bus.bprn_n       = r.bprn_n;
  assign bus.xack_n       = r.xack_n;
  assign bus.busy_far_o   = BUS_ASSERTED;
  assign bus.busy_far_oe  = r.busy_oe;
  assign bus.cbreq_far_o  = BUS_ASSERTED;
  assign bus.cbreq_far_oe = r.cbreq_oe;
  assign other_grant_out  = r.grant;
  assign chain_prio_out   = r.chain;

endmodule // sba_bus_end
`default_nettype wire

// file: tb/sba_arbiter_properties.sv
// Assertions on the wires between the arbiter and its far end
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter_properties
  import sba_pkg::*;
#(
  parameter int unsigned CMD_DELAY = CMD_DELAY_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic bprn_n,
  input wire logic bpro_n,
  input wire logic breq_n,
  input wire logic busy_arb_o,
  input wire logic busy_arb_oe,
  input wire logic cbreq_arb_o,
  input wire logic cbreq_arb_oe,
  input wire logic busy_n,
  input wire logic cbreq_n,
  input wire logic adr_en_n,
  input wire logic mrdc_n,
  input wire logic mwtc_n,
  input wire logic iorc_n,
  input wire logic iowc_n,
  input wire logic xack_n
);
  logic [3:0] cmd;
  logic [5:0] aen_cnt;

  assign cmd = ~{mrdc_n, mwtc_n, iorc_n, iowc_n};

  // Cycles the address has been enabled; saturates so long parks cannot wrap
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || adr_en_n) begin
      aen_cnt <= 6'h00;
    end else if (aen_cnt != 6'h3f) begin
      aen_cnt <= aen_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_reset_idle: assert property (
    $fell(rst_in) |-> breq_n && adr_en_n && !busy_arb_oe && !cbreq_arb_oe && cmd == 4'h0)
    else $error("bus lines not idle after reset");
  a_open_coll: assert property (
    (!busy_arb_oe || !busy_arb_o) && (!cbreq_arb_oe || !cbreq_arb_o))
    else $error("open collector driven high");
  a_busy_grant: assert property (
    busy_arb_oe == !adr_en_n)
    else $error("busy drive differs from grant");
  a_grant_cause: assert property (
    $fell(adr_en_n) |-> !$past(bprn_n) && $past(busy_n))
    else $error("grant without priority or free bus");
  a_chain_block: assert property (
    !breq_n |-> bpro_n)
    else $error("priority passed on while requesting");
  a_breq_common: assert property (
    $fell(breq_n) && adr_en_n |-> cbreq_arb_oe)
    else $error("request without common request");
  a_cmd_settle: assert property (
    cmd != 4'h0 |-> 32'(aen_cnt) >= CMD_DELAY)
    else $error("command too soon after address");
  a_cmd_onehot: assert property (
    $onehot0(cmd))
    else $error("more than one command strobe");
  a_cmd_addr: assert property (
    cmd != 4'h0 |-> !adr_en_n)
    else $error("command without address enable");
  a_overrule_release: assert property (
    !adr_en_n && bprn_n && !xack_n |-> ##[1:3] adr_en_n)
    else $error("overruled owner kept the bus");
  a_keep_bus: assert property (
    !adr_en_n && !bprn_n && cbreq_n |=> !adr_en_n)
    else $error("bus dropped with nobody waiting");
  a_ack_cause: assert property (
    !xack_n |-> $past(cmd) != 4'h0)
    else $error("acknowledge without command");

  c_grant: cover property ($fell(adr_en_n));
  c_overrule: cover property (!adr_en_n && bprn_n && !xack_n);
  c_park: cover property (!adr_en_n && breq_n && cmd == 4'h0);
endmodule // sba_arbiter_properties
`default_nettype wire

// file: tb/sba_arbiter_test.sv
// Self-checking bench joining the arbiter to its far end
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter_test;
  localparam int unsigned CMD_D = 1;
  logic       ref_clk;
  logic       rst;
  logic       req;
  logic       rd;
  logic       wr;
  logic       mem;
  logic       ser;
  logic       cprio;
  logic [2:0] obreq;
  logic       obusy;
  logic       ocbreq;
  logic       address_enable_grant;
  logic       command_output_enable;
  logic [1:0] st;
  logic [2:0] ogrant;
  logic       cprio_out;
  int         n_fail;
  int         n_compared;

  sba_bus_if bus ();
  sba_arbiter #(.CMD_DELAY(CMD_D)) u_sba_arbiter (
    .ref_clk_in(ref_clk), .rst_in(rst), .master_transfer_request_in(req),
    .read_req_in(rd), .write_req_in(wr), .mem_space_in(mem), .bus(bus.device),
    .address_enable_grant_out(address_enable_grant), .command_output_enable_out(command_output_enable), .arb_state_out(st));
  sba_bus_end u_sba_bus_end (
    .ref_clk_in(ref_clk), .rst_in(rst), .serial_mode_in(ser), .chain_prio_in(cprio),
    .other_breq_in(obreq), .other_busy_in(obusy), .other_cbreq_in(ocbreq), .bus(bus.far),
    .other_grant_out(ogrant), .chain_prio_out(cprio_out));
  sba_arbiter_properties #(.CMD_DELAY(CMD_D)) u_sba_arbiter_properties (
    .ref_clk_in(ref_clk), .rst_in(rst), .bprn_n(bus.bprn_n), .bpro_n(bus.bpro_n),
    .breq_n(bus.breq_n), .busy_arb_o(bus.busy_arb_o), .busy_arb_oe(bus.busy_arb_oe),
    .cbreq_arb_o(bus.cbreq_arb_o), .cbreq_arb_oe(bus.cbreq_arb_oe), .busy_n(bus.busy_n),
    .cbreq_n(bus.cbreq_n), .adr_en_n(bus.adr_en_n), .mrdc_n(bus.mrdc_n),
    .mwtc_n(bus.mwtc_n), .iorc_n(bus.iorc_n), .iowc_n(bus.iowc_n), .xack_n(bus.xack_n));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [3:0] strb();
    return ~{bus.mrdc_n, bus.mwtc_n, bus.iorc_n, bus.iowc_n};
  endfunction

  function automatic logic pick(input int sel);
    case (sel)
      0: return command_output_enable;
      1: return bus.xack_n;
      default: return address_enable_grant;
    endcase
  endfunction

  task automatic wait_until(input string name, input int sel, input logic lvl);
    int i;
    i = 0;
    while (pick(sel) !== lvl && i < 60) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk(name, lvl, pick(sel));
  endtask

  // Mode 1 checks request latency, mode 2 expects a refusal first
  task automatic xfer_start(input logic w, input logic m, input int mode);
    @(posedge ref_clk);
    req <= 1'b1;
    rd <= ~w;
    wr <= w;
    mem <= m;
    if (mode == 1) begin
      repeat (2) @(posedge ref_clk);
      #1;
      chk("breq_n", 1'b1, bus.breq_n);
      @(posedge ref_clk);
      #1;
      chk("breq_n", 1'b0, bus.breq_n);
      chk("bpro_n", 1'b1, bus.bpro_n);
    end
    if (mode == 2) begin
      repeat (10) @(posedge ref_clk);
      #1;
      chk("aen", 1'b0, address_enable_grant);
      chk("breq_n", 1'b0, bus.breq_n);
      chk("cbreq_n", 1'b0, bus.cbreq_n);
      @(posedge ref_clk);
      obusy <= 1'b0;
      obreq <= 3'h0;
    end
    wait_until("oen", 0, 1'b1);
    chk("adr_en_n", 1'b0, bus.adr_en_n);
    chk4("strobes", {m & ~w, m & w, ~m & ~w, ~m & w}, strb());
  endtask

  task automatic xfer_end();
    wait_until("xack_n", 1, 1'b0);
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("oen", 1'b0, command_output_enable);
    chk4("strobes", 4'h0, strb());
    chk("aen", 1'b1, address_enable_grant);
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    req = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    mem = 1'b0;
    ser = 1'b1;
    cprio = 1'b1;
    obreq = 3'h0;
    obusy = 1'b0;
    ocbreq = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("adr_en_n", 1'b1, bus.adr_en_n);
    chk("breq_n", 1'b1, bus.breq_n);
    chk4("state", 4'h0, {2'h0, st});
    @(posedge ref_clk);
    req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("breq_n", 1'b1, bus.breq_n);
    chk("chain_prio_out", 1'b1, cprio_out);
    for (int k = 0; k < 4; k++) begin
      xfer_start(k[0], k[1], (k == 0) ? 1 : 0);
      xfer_end();
    end
    repeat (5) @(posedge ref_clk);
    #1;
    chk4("state", 4'h3, {2'h0, st});
    @(posedge ref_clk);
    ocbreq <= 1'b1;
    wait_until("aen", 2, 1'b0);
    @(posedge ref_clk);
    ocbreq <= 1'b0;
    rst <= 1'b1;
    ser <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    obusy <= 1'b1;
    xfer_start(1'b1, 1'b1, 2);
    xfer_end();
    @(posedge ref_clk);
    obreq <= 3'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk4("grants", 4'h1, {1'b0, ogrant});
    xfer_start(1'b0, 1'b0, 2);
    xfer_end();
    xfer_start(1'b0, 1'b1, 0);
    @(posedge ref_clk);
    obreq <= 3'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("aen", 1'b1, address_enable_grant);
    wait_until("xack_n", 1, 1'b0);
    wait_until("aen", 2, 1'b0);
    chk("breq_n", 1'b0, bus.breq_n);
    @(posedge ref_clk);
    obreq <= 3'h0;
    wait_until("oen", 0, 1'b1);
    xfer_end();
    end_sim();
  end

  // The sequence needs well under a thousand cycles; allow several times that
  initial begin
    #30000;
    n_fail++;
    end_sim();
  end
endmodule // sba_arbiter_test
`default_nettype wire
